// file: verilog/anptx_top.sv
// Summary of operation
// - Bit 15 requests more pages, read/write, resets to 0.
// - Bit 14 is reserved; writes dropped, always reads zero.
// - Bit 13 selects message page (1) or unformatted page, resets to 1.
// - Bit 12 says the device can comply with the message, resets to 0.
// - Bit 11 is read-only, inverse of toggle in last exchanged word, cleared to 0 by restart.
// - Bits 10:0 hold the read/write message or unformatted code.
// - Code resets to 000 0000 0001, a null page.
//
// Implementation choice: the Wishbone slave port.
module anptx_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        page_load_i,
  input  wire logic        page_sent_i,
  input  wire logic        an_restart_i,
  output logic      [15:0] page_word_o,
  output logic             page_valid_o
);

  anptx_pkg::anptx_acc_t  acc;
  anptx_pkg::anptx_word_t cur_word;
  logic [31:0]            rdata;
  logic                   sync_bit;

  // Software-held fields of the next page transmit register
  logic        more_pages_request;
  logic        message_page_flag;
  logic        comply_acknowledge;
  logic [10:0] code;
  logic        next_more;
  logic        next_msg;
  logic        next_comply;
  logic [10:0] next_code;

  // Transmit side state
  logic [15:0] next_word;
  logic        next_valid;
  logic [7:0]  exch_cnt;
  logic [7:0]  next_cnt;

  logic        wr_page;

  // Byte-lane merge of one register byte
  function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en);
    lane_merge = en ? new_v : old_v;
  endfunction

  // Pack the status word
  function automatic logic [31:0] pack_status(input logic       pending,
                                              input logic       sbit,
                                              input logic [7:0] cnt);
    logic [31:0] s;
    s = 32'h0000_0000;
    s[anptx_pkg::ST_PENDING] = pending;
    s[anptx_pkg::ST_SYNC] = sbit;
    s[anptx_pkg::ST_CNT_LSB +: anptx_pkg::CNT_W] = cnt;
    pack_status = s;
  endfunction

  anptx_wb_slave u_bus (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .rdata_i  (rdata),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .acc_o    (acc)
  );

  anptx_sync_bit u_sync (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .restart_i   (an_restart_i),
    .exch_i      (page_sent_i),
    .sent_sync_i (page_word_o[anptx_pkg::BIT_SYNC]),
    .sync_o      (sync_bit)
  );

  // Current register image, reserved bit forced low
  always_comb begin
    cur_word.more_pages_request   = more_pages_request;
    cur_word.reserved             = 1'h0;
    cur_word.message_page_flag    = message_page_flag;
    cur_word.comply_acknowledge   = comply_acknowledge;
    cur_word.alternating_sync_bit = sync_bit;
    cur_word.code                 = code;
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (acc.idx == anptx_pkg::IDX_NEXT_PAGE) begin
      rdata[15:0] = cur_word;
    end else if (acc.idx == anptx_pkg::IDX_STATUS) begin
      rdata = pack_status(page_valid_o, sync_bit, exch_cnt);
    end
  end

  assign wr_page = acc.wr && (acc.idx == anptx_pkg::IDX_NEXT_PAGE);

  // Next values of the writable fields; bit 14 and bit 11 ignore writes
  always_comb begin
    logic [7:0] lo;
    logic [7:0] hi;
    lo = lane_merge(code[7:0], acc.data[7:0], wr_page && acc.sel[0]);
    hi = lane_merge({more_pages_request, 1'h0, message_page_flag, comply_acknowledge, 1'h0, code[10:8]},
                    acc.data[15:8], wr_page && acc.sel[1]);
    next_more   = hi[anptx_pkg::BIT_MORE - 8];
    next_msg    = hi[anptx_pkg::BIT_MSG - 8];
    next_comply = hi[anptx_pkg::BIT_COMPLY - 8];
    next_code   = {hi[2:0], lo};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      more_pages_request <= anptx_pkg::RST_MORE;
      message_page_flag  <= anptx_pkg::RST_MSG;
      comply_acknowledge <= anptx_pkg::RST_COMPLY;
      code               <= anptx_pkg::RST_CODE;
    end else if (ce_i) begin
      more_pages_request <= next_more;
      message_page_flag  <= next_msg;
      comply_acknowledge <= next_comply;
      code               <= next_code;
    end
  end

  // Outgoing word: snapshot on load, pending until sent or restart; load beats both
  always_comb begin
    next_word  = page_word_o;
    next_valid = page_valid_o;
    next_cnt   = exch_cnt;
    if (page_sent_i) begin
      next_valid = 1'h0;
      next_cnt   = exch_cnt + 8'h01;
    end
    if (an_restart_i) begin
      next_valid = 1'h0;
    end
    if (page_load_i) begin
      next_word  = cur_word;
      next_valid = 1'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_word_o  <= {anptx_pkg::RST_MORE, 1'h0, anptx_pkg::RST_MSG, anptx_pkg::RST_COMPLY,
                       anptx_pkg::RST_SYNC, anptx_pkg::RST_CODE};
      page_valid_o <= 1'h0;
      exch_cnt     <= anptx_pkg::RST_CNT;
    end else if (ce_i) begin
      page_word_o  <= next_word;
      page_valid_o <= next_valid;
      exch_cnt     <= next_cnt;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_page_write_hi;
    ce_i && wr_page && acc.sel[1];
  endsequence

  sequence s_page_write_lo;
    ce_i && wr_page && acc.sel[0];
  endsequence

  sequence s_reset_release;
    $past(rst_i) && !rst_i;
  endsequence

  a_reset_more_comply: assert property (s_reset_release |-> !more_pages_request && !comply_acknowledge)
    else $error("more-pages or comply not zero after reset");
  a_reset_msg_code: assert property (s_reset_release |-> message_page_flag && code == anptx_pkg::RST_CODE)
    else $error("message flag or code wrong after reset");
  a_reserved_reads_zero: assert property (wb_ack_o && !wb_we_i && acc.idx == anptx_pkg::IDX_NEXT_PAGE |->
    !wb_dat_o[anptx_pkg::BIT_RSVD])
    else $error("reserved bit read as one");
  a_write_high_fields: assert property (s_page_write_hi |=>
    more_pages_request == $past(acc.data[15]) && message_page_flag == $past(acc.data[13])
    && comply_acknowledge == $past(acc.data[12]))
    else $error("high byte fields not written");
  a_write_code_low: assert property (s_page_write_lo |=> code[7:0] == $past(acc.data[7:0]))
    else $error("code low byte not written");
  a_load_word: assert property (ce_i && page_load_i |=>
    page_valid_o && page_word_o == $past(cur_word) && !page_word_o[anptx_pkg::BIT_RSVD])
    else $error("outgoing word not loaded from register");
  a_sync_in_word: assert property (ce_i && page_load_i |=> page_word_o[anptx_pkg::BIT_SYNC] == $past(sync_bit))
    else $error("outgoing toggle not device value");
  a_pending_clears: assert property (ce_i && page_sent_i && !page_load_i |=> !page_valid_o ##1 1'h1)
    else $error("pending not cleared after exchange");

  // Bus request kinds, split by the word index they address
  sequence s_new_request;
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_page_read;
    s_new_request ##0 acc.idx == anptx_pkg::IDX_NEXT_PAGE;
  endsequence

  sequence s_status_read;
    s_new_request ##0 acc.idx == anptx_pkg::IDX_STATUS;
  endsequence

  sequence s_other_read;
    s_new_request ##0 acc.idx != anptx_pkg::IDX_NEXT_PAGE && acc.idx != anptx_pkg::IDX_STATUS;
  endsequence

  // Read data built from the live fields, upper half zero
  a_page_read_image: assert property (s_page_read |=>
    wb_dat_o == {16'h0000, $past(more_pages_request), 1'h0, $past(message_page_flag),
                 $past(comply_acknowledge), $past(sync_bit), $past(code)})
    else $error("register read differs from register fields");

  a_status_read: assert property (s_status_read |=>
    wb_dat_o[anptx_pkg::ST_PENDING] == $past(page_valid_o) && wb_dat_o[anptx_pkg::ST_SYNC] == $past(sync_bit)
    && wb_dat_o[anptx_pkg::ST_CNT_LSB +: anptx_pkg::CNT_W] == $past(exch_cnt))
    else $error("status read differs from pending, toggle or count");

  a_unmapped_zero: assert property (s_other_read |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped word did not read zero");

  a_ack_idle: assert property (ce_i && !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");

  a_dat_holds: assert property (ce_i && !(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data changed without request");

  // Writes touch only their own lanes; the toggle never takes write data
  a_code_high_write: assert property (s_page_write_hi |=> code[10:8] == $past(acc.data[10:8]))
    else $error("code high bits not written");

  a_low_lane_only: assert property (ce_i && wr_page && !acc.sel[1] |=>
    $stable(more_pages_request) && $stable(message_page_flag) && $stable(comply_acknowledge))
    else $error("high byte fields changed on low lane write");

  a_fields_hold: assert property (!(ce_i && wr_page) |=>
    $stable(more_pages_request) && $stable(message_page_flag) && $stable(comply_acknowledge) && $stable(code))
    else $error("register field changed without write");

  a_sync_read_only: assert property (s_page_write_hi ##0 !page_sent_i && !an_restart_i |=>
    $stable(sync_bit))
    else $error("toggle changed by a register write");

  // Exchange bookkeeping: toggle, pending and count
  sequence s_exchange;
    ce_i && page_sent_i && !an_restart_i;
  endsequence

  a_toggle_flips: assert property (s_exchange |=> sync_bit == !$past(page_word_o[anptx_pkg::BIT_SYNC]))
    else $error("toggle not inverse of exchanged word");

  a_restart_toggle: assert property (ce_i && an_restart_i |=> !sync_bit)
    else $error("toggle not cleared by restart");

  a_restart_pending: assert property (ce_i && an_restart_i && !page_load_i |=> !page_valid_o)
    else $error("pending not cleared by restart");

  a_count_step: assert property (ce_i && page_sent_i |=> exch_cnt == $past(exch_cnt) + 8'h01)
    else $error("exchange count did not advance");

  a_valid_source: assert property (!(ce_i && page_load_i) |=> !$rose(page_valid_o))
    else $error("pending set without a load");

  a_word_holds: assert property (!(ce_i && page_load_i) |=> $stable(page_word_o))
    else $error("outgoing word changed without a load");

  a_reset_toggle: assert property (s_reset_release |-> !sync_bit && !page_valid_o)
    else $error("toggle or pending not zero after reset");

  // Clock enable low freezes the transmit side and the bus answer
  a_freeze: assert property (!ce_i |=>
    $stable(page_word_o) && $stable(page_valid_o) && $stable(exch_cnt) && $stable(wb_ack_o))
    else $error("state moved while clock enable low");

endmodule

// file: verilog/anptx_pkg.sv
package anptx_pkg;

  // Bus geometry
  localparam int unsigned ADR_W     = 8;
  localparam int unsigned DAT_W     = 32;
  localparam int unsigned SEL_W     = 4;
  localparam int unsigned IDX_W     = 6;

  // Register indices; byte address is four times the index
  localparam logic [5:0]  IDX_NEXT_PAGE = 6'h07;
  localparam logic [5:0]  IDX_STATUS    = 6'h08;

  // Next page word field positions
  localparam int unsigned BIT_MORE  = 15;
  localparam int unsigned BIT_RSVD  = 14;
  localparam int unsigned BIT_MSG   = 13;
  localparam int unsigned BIT_COMPLY = 12;
  localparam int unsigned BIT_SYNC  = 11;
  localparam int unsigned CODE_MSB  = 10;
  localparam int unsigned CODE_LSB  = 0;
  localparam int unsigned CODE_W    = 11;
  localparam int unsigned WORD_W    = 16;

  // Next page word reset values
  localparam logic        RST_MORE   = 1'h0;
  localparam logic        RST_MSG    = 1'h1;
  localparam logic        RST_COMPLY = 1'h0;
  localparam logic        RST_SYNC   = 1'h0;
  localparam logic [10:0] RST_CODE   = 11'h001;

  // Status register layout
  localparam int unsigned ST_PENDING = 0;
  localparam int unsigned ST_SYNC    = 1;
  localparam int unsigned ST_CNT_LSB = 8;
  localparam int unsigned CNT_W      = 8;
  localparam logic [7:0]  RST_CNT    = 8'h00;

  // Outgoing link code word layout
  typedef struct packed {
    logic        more_pages_request;
    logic        reserved;
    logic        message_page_flag;
    logic        comply_acknowledge;
    logic        alternating_sync_bit;
    logic [10:0] code;
  } anptx_word_t;

  // Committed register access from the bus slave
  typedef struct packed {
    logic        wr;
    logic [5:0]  idx;
    logic [3:0]  sel;
    logic [31:0] data;
  } anptx_acc_t;

endpackage

// file: verilog/anptx_wb_slave.sv
module anptx_wb_slave (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [31:0]             rdata_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  output anptx_pkg::anptx_acc_t        acc_o
);

  logic        next_ack;
  logic [31:0] next_dat;

  // Word index seen by the read mux and the write commit
  always_comb begin
    acc_o.wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && ce_i;
    acc_o.idx  = wb_adr_i[7:2];
    acc_o.sel  = wb_sel_i;
    acc_o.data = wb_dat_i;
  end

  // Ack one cycle after request, dropped the cycle after
  always_comb begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = next_ack ? rdata_i : wb_dat_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  sequence s_req;
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
    s_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule

// file: verilog/anptx_sync_bit.sv
module anptx_sync_bit (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic restart_i,
  input  wire logic exch_i,
  input  wire logic sent_sync_i,
  output logic      sync_o
);

  logic next_sync;

  // Next value is zero on restart, else on an exchange the inverse of the bit just exchanged, else held
  always_comb begin
    next_sync = sync_o;
    if (restart_i) begin
      next_sync = anptx_pkg::RST_SYNC;
    end else if (exch_i) begin
      next_sync = !sent_sync_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_o <= anptx_pkg::RST_SYNC;
    end else if (ce_i) begin
      sync_o <= next_sync;
    end
  end

  a_sync_inverts: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && exch_i && !restart_i |=> sync_o == !$past(sent_sync_i))
    else $error("sync bit not inverse of exchanged value");
  a_sync_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ce_i && (exch_i || restart_i)) |=> $stable(sync_o))
    else $error("sync bit changed without exchange");

endmodule

// file: bench/anptx_top_tb.sv
module anptx_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_i;
  logic        rst_i;
  logic        ce_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        page_load_i;
  logic        page_sent_i;
  logic        an_restart_i;
  logic [15:0] page_word_o;
  logic        page_valid_o;
  int          errors;
  int          n_tests;
  logic [31:0] rd;

  anptx_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .page_load_i(page_load_i), .page_sent_i(page_sent_i), .an_restart_i(an_restart_i),
    .page_word_o(page_word_o), .page_valid_o(page_valid_o)
  );

  // Free running 125 MHz clock
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One comparison with report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic Wishbone single cycle, held until ack is sampled
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [3:0] s,
                          input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'h1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
    if (k >= 20) begin
      errors++;
      $display("wrong value ack expected 1 seen timeout");
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'h1, a, s, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(1'h0, a, 4'h0, 32'h0000_0000, q);
    chk("read data", exp, q);
  endtask

  // One-cycle pulse on {restart, sent, load}, outputs looked at after the taking edge
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_i);
    {an_restart_i, page_sent_i, page_load_i} <= m;
    @(posedge clk_i);
    {an_restart_i, page_sent_i, page_load_i} <= 3'h0;
    @(negedge clk_i);
  endtask

  // Main sequence
  initial begin
    errors = 0;
    n_tests = 0;
    rst_i = 1'h1;
    ce_i = 1'h1;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    page_load_i = 1'h0;
    page_sent_i = 1'h0;
    an_restart_i = 1'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    @(negedge clk_i);
    chk("word after reset", 32'h0000_2001, {16'h0000, page_word_o});
    chk("valid after reset", 32'h0000_0000, {31'h0000_0000, page_valid_o});
    rd_chk(8'h1C, 32'h0000_2001);
    rd_chk(8'h3C, 32'h0000_0000);
    wr(8'h1C, 4'h3, 32'hFFFF_FFFF);
    rd_chk(8'h1C, 32'h0000_B7FF);
    wr(8'h1C, 4'h1, 32'h0000_0000);
    rd_chk(8'h1C, 32'h0000_B700);
    wr(8'h1C, 4'h3, 32'h0000_0000);
    rd_chk(8'h1C, 32'h0000_0000);
    wr(8'h1C, 4'h3, 32'h0000_9555);
    rd_chk(8'h1C, 32'h0000_9555);
    pulse(3'h1);
    chk("loaded word", 32'h0000_9555, {16'h0000, page_word_o});
    chk("valid after load", 32'h0000_0001, {31'h0000_0000, page_valid_o});
    pulse(3'h2);
    chk("valid after sent", 32'h0000_0000, {31'h0000_0000, page_valid_o});
    rd_chk(8'h1C, 32'h0000_9D55);
    wr(8'h1C, 4'h3, 32'h0000_9555);
    rd_chk(8'h1C, 32'h0000_9D55);
    pulse(3'h1);
    chk("second word", 32'h0000_9D55, {16'h0000, page_word_o});
    pulse(3'h2);
    rd_chk(8'h1C, 32'h0000_9555);
    pulse(3'h1);
    pulse(3'h2);
    rd_chk(8'h1C, 32'h0000_9D55);
    pulse(3'h4);
    rd_chk(8'h1C, 32'h0000_9555);
    pulse(3'h1);
    chk("word after restart", 32'h0000_9555, {16'h0000, page_word_o});
    // Clock enable low: an exchange pulse must leave everything frozen
    @(posedge clk_i);
    ce_i <= 1'h0;
    pulse(3'h2);
    chk("valid while frozen", 32'h0000_0001, {31'h0000_0000, page_valid_o});
    @(posedge clk_i);
    ce_i <= 1'h1;
    rd_chk(8'h20, 32'h0000_0301);
    // Reset in mid-run after every field was written
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rd_chk(8'h1C, 32'h0000_2001);
    rd_chk(8'h20, 32'h0000_0000);
    report_and_stop();
  end
endmodule
